// File: src/dsr_pkg.sv
// Constants for the dual converter serial readout block
package dsr_pkg;
  localparam int RES_W = 12;
  localparam int LEAD_ZEROS = 2;
  localparam int TRAIL_ZEROS = 2;
  localparam int HALF_BITS = LEAD_ZEROS + RES_W + TRAIL_ZEROS;
  localparam int FRAME_BITS = 2 * HALF_BITS;
  localparam int TRACK_AFTER_FALLS = 13;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_TRACK = 6'(TRACK_AFTER_FALLS);
  localparam logic [CNT_W-1:0] CNT_END = 6'(FRAME_BITS);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_SPENT} dsr_state_type;
endpackage : dsr_pkg

// File: src/dsr_lane_if.sv
// Carrier between the control logic and one channel shift register
`timescale 1ns/1ps
`default_nettype none
interface dsr_lane_if #(parameter int WIDTH = 32);
  logic load;
  logic shift;
  logic [WIDTH-1:0] word;
  logic bit_out;
  modport ctrl (output load, output shift, output word, input bit_out);
  modport lane (input load, input shift, input word, output bit_out);
endinterface : dsr_lane_if
`default_nettype wire

// File: src/dsr_lane.sv
// One channel output shift register
`timescale 1ns/1ps
`default_nettype none
module dsr_lane #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  dsr_lane_if.lane lif
);
  typedef struct packed {
    logic [WIDTH-1:0] sh;
  } dsr_lane_state_type;

  dsr_lane_state_type st_ff;
  dsr_lane_state_type nxt_st;

  // Refused at elaboration: a one-bit lane has nothing to shift
  if (WIDTH < 2) begin : g_width_chk
    $error("dsr_lane: WIDTH too small");
  end

  // Load wins over shift; msb is always the bit on the line
  always_comb begin
    nxt_st = st_ff;
    if (lif.load) begin
      nxt_st.sh = lif.word;
    end else if (lif.shift) begin
      nxt_st.sh = {st_ff.sh[WIDTH-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lif.bit_out = st_ff.sh[WIDTH-1];
endmodule : dsr_lane
`default_nettype wire

// File: src/dsr_top.sv
// Serial conversion and readout control of a dual sampling converter
`timescale 1ns/1ps
`default_nettype none
module dsr_top #(
  parameter int RES_BITS = dsr_pkg::RES_W
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLK,
  input wire logic [RES_BITS-1:0] RESULT_A,
  input wire logic [RES_BITS-1:0] RESULT_B,
  output logic SERIAL_OUT_FIRST,
  output logic SERIAL_OUT_FIRST_OE,
  output logic SERIAL_OUT_SECOND,
  output logic SERIAL_OUT_SECOND_OE,
  output logic HOLD_ACTIVE
);
  import dsr_pkg::*;

  typedef struct packed {
    dsr_state_type state;
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [CNT_W-1:0] fall_cnt;
    logic hold;
    logic oe;
    logic [RES_BITS-1:0] cap_a;
    logic [RES_BITS-1:0] cap_b;
  } dsr_ctrl_type;

  dsr_ctrl_type st_ff;
  dsr_ctrl_type nxt_st;

  // The logic keys on RES_W-wide frames; other widths would break counts
  if (RES_BITS != RES_W) begin : g_res_chk
    $error("dsr_top: RES_BITS must equal RES_W");
  end

  dsr_lane_if #(.WIDTH(FRAME_BITS)) lane_a ();
  dsr_lane_if #(.WIDTH(FRAME_BITS)) lane_b ();

  // Pins are sampled three times; stage 2 and 3 feed edge detection only
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic active;
  assign cs_fall = st_ff.cs_sync[2] & ~st_ff.cs_sync[1];
  assign cs_rise = ~st_ff.cs_sync[2] & st_ff.cs_sync[1];
  assign sclk_fall = st_ff.sclk_sync[2] & ~st_ff.sclk_sync[1];
  assign sclk_rise = ~st_ff.sclk_sync[2] & st_ff.sclk_sync[1];
  assign active = (st_ff.state == ST_SHIFT);

  // Frame words: own result first, other channel in the second half
  logic [FRAME_BITS-1:0] word_a;
  logic [FRAME_BITS-1:0] word_b;
  assign word_a = {2'b00, RESULT_A, 2'b00, 2'b00, RESULT_B, 2'b00};
  assign word_b = {2'b00, RESULT_B, 2'b00, 2'b00, RESULT_A, 2'b00};

  // Both lanes take the same load and shift strobes
  assign lane_a.load = cs_fall & (st_ff.state == ST_IDLE);
  assign lane_b.load = cs_fall & (st_ff.state == ST_IDLE);
  assign lane_a.shift = active & sclk_fall;
  assign lane_b.shift = active & sclk_fall;
  assign lane_a.word = word_a;
  assign lane_b.word = word_b;

  dsr_lane #(.WIDTH(FRAME_BITS)) u_lane_a (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .lif(lane_a)
  );

  dsr_lane #(.WIDTH(FRAME_BITS)) u_lane_b (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .lif(lane_b)
  );

  // Sequencer: select edges start and stop, clock edges pace
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cs_sync = {st_ff.cs_sync[1:0], CHIP_SELECT_N};
    nxt_st.sclk_sync = {st_ff.sclk_sync[1:0], SERIAL_CLK};
    case (st_ff.state)
      ST_IDLE: begin
        if (cs_fall) begin
          nxt_st.state = ST_SHIFT;
          nxt_st.hold = 1'b1;
          nxt_st.oe = 1'b1;
          nxt_st.fall_cnt = CNT_RST;
          nxt_st.cap_a = RESULT_A;
          nxt_st.cap_b = RESULT_B;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          // Abort takes priority over any clock edge this cycle
          nxt_st.state = ST_IDLE;
          nxt_st.oe = 1'b0;
          nxt_st.hold = 1'b0;
        end else if (sclk_fall) begin
          nxt_st.fall_cnt = st_ff.fall_cnt + 6'h01;
          if (st_ff.fall_cnt == CNT_END - 6'h01) begin
            nxt_st.state = ST_SPENT;
            nxt_st.oe = 1'b0;
          end
        end else if (sclk_rise && st_ff.fall_cnt >= CNT_TRACK) begin
          nxt_st.hold = 1'b0;
        end
      end
      ST_SPENT: begin
        // Select may idle low; a new frame needs it high first
        if (cs_rise) begin
          nxt_st.state = ST_IDLE;
          nxt_st.hold = 1'b0;
        end else if (sclk_rise) begin
          nxt_st.hold = 1'b0;
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
        nxt_st.oe = 1'b0;
        nxt_st.hold = 1'b0;
      end
    endcase
  end

  // Synchronisers start high so no false select edge after reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff.state <= ST_IDLE;
      st_ff.cs_sync <= 3'b111;
      st_ff.sclk_sync <= 3'b111;
      st_ff.fall_cnt <= CNT_RST;
      st_ff.hold <= 1'b0;
      st_ff.oe <= 1'b0;
      st_ff.cap_a <= '0;
      st_ff.cap_b <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Data and enables come straight from flip-flops
  assign SERIAL_OUT_FIRST = lane_a.bit_out;
  assign SERIAL_OUT_SECOND = lane_b.bit_out;
  assign SERIAL_OUT_FIRST_OE = st_ff.oe;
  assign SERIAL_OUT_SECOND_OE = st_ff.oe;
  assign HOLD_ACTIVE = st_ff.hold;

  default clocking dsr_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  AST_START_HOLD: assert property (
    (cs_fall && st_ff.state == ST_IDLE) |=> (HOLD_ACTIVE && SERIAL_OUT_FIRST_OE
      && SERIAL_OUT_SECOND_OE)
  ) else $error("select fall did not hold and drive");

  AST_LEAD_ZERO: assert property (
    (cs_fall && st_ff.state == ST_IDLE) |=> (!SERIAL_OUT_FIRST && !SERIAL_OUT_SECOND)
      ##0 (!SERIAL_OUT_FIRST throughout (active && st_ff.fall_cnt < 6'h02)[*1])
  ) else $error("leading zero missing");

  AST_ABORT: assert property (
    (cs_rise && active) |=> (!SERIAL_OUT_FIRST_OE && !SERIAL_OUT_SECOND_OE && !HOLD_ACTIVE)
  ) else $error("select rise did not release outputs");

  AST_TRACK: assert property (
    (active && !cs_rise && !sclk_fall && sclk_rise && st_ff.fall_cnt >= CNT_TRACK)
      |=> !HOLD_ACTIVE
  ) else $error("no return to track after 13th fall");

  AST_HOLD_EARLY: assert property (
    $fell(HOLD_ACTIVE) |-> ($past(st_ff.fall_cnt) >= CNT_TRACK || $past(cs_rise))
  ) else $error("hold released too early");

  AST_LSB: assert property (
    (active && !cs_rise && sclk_fall && st_ff.fall_cnt == 6'h0C)
      |=> (SERIAL_OUT_FIRST == st_ff.cap_a[0] && SERIAL_OUT_SECOND == st_ff.cap_b[0])
  ) else $error("last result bit not on 13th fall");

  AST_TRAIL: assert property (
    (active && !cs_rise && sclk_fall && st_ff.fall_cnt == 6'h0D)
      |=> (!SERIAL_OUT_FIRST && !SERIAL_OUT_SECOND)
  ) else $error("trailing zero missing");

  AST_SWAP: assert property (
    (active && !cs_rise && sclk_fall && st_ff.fall_cnt == 6'h11)
      |=> (SERIAL_OUT_FIRST == st_ff.cap_b[RES_BITS-1]
        && SERIAL_OUT_SECOND == st_ff.cap_a[RES_BITS-1])
  ) else $error("channels not swapped in extended read");

  AST_END32: assert property (
    (active && !cs_rise && sclk_fall && st_ff.fall_cnt == CNT_END - 6'h01)
      |=> !SERIAL_OUT_FIRST_OE ##1 !SERIAL_OUT_FIRST_OE
  ) else $error("line not released at 32nd fall");

  // Fall count picks the result bit due on the line, so both lanes are checked for fall counts 2 to 13
  localparam logic [CNT_W-1:0] LSB_FALLS = CNT_W'(LEAD_ZEROS + RES_BITS - 1);
  logic [3:0] res_idx;
  assign res_idx = 4'(LSB_FALLS - st_ff.fall_cnt);

  AST_LANE_BITS: assert property (
    (active && st_ff.fall_cnt >= 6'h02 && st_ff.fall_cnt <= LSB_FALLS)
      |-> (SERIAL_OUT_FIRST == st_ff.cap_a[res_idx]
        && SERIAL_OUT_SECOND == st_ff.cap_b[res_idx])
  ) else $error("lanes not shifting the results in step");

  AST_LOCKSTEP: assert property (
    (SERIAL_OUT_FIRST_OE == SERIAL_OUT_SECOND_OE) && (lane_a.shift == lane_b.shift)
  ) else $error("lanes out of lockstep");
endmodule : dsr_top
`default_nettype wire

// File: bench/dsr_host.sv
// Behavioural host that frames readouts
`timescale 1ns/1ps
`default_nettype none
module dsr_host (
  input wire logic clk,
  input wire logic d1,
  input wire logic oe1,
  input wire logic d2,
  input wire logic oe2,
  input wire logic hold,
  output logic cs_n,
  output logic sclk
);
  logic [31:0] bits1, bits2;
  logic [32:0] rbits1, rbits2;
  logic hold_sel, hold_pre, hold_post, oe_end, oe_rel, hold_end;
  logic last1 = 1'b0;
  logic last2 = 1'b0;
  logic w1, w2;
  // Released line shows inverse of last value, never a settled level
  always @(posedge clk) begin
    if (oe1) last1 <= d1;
    if (oe2) last2 <= d2;
  end
  assign w1 = oe1 ? d1 : ~last1;
  assign w2 = oe2 ? d2 : ~last2;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  // One frame of nf falls; clock idles high, still between frames
  task automatic frame(input int nf);
    @(posedge clk);
    #1 cs_n = 1'b0;
    #150 hold_sel = hold;
    #50;
    for (int n = 1; n <= nf; n++) begin
      bits1[n-1] = w1;
      bits2[n-1] = w2;
      sclk = 1'b0;
      #100 if (n == 13) hold_pre = hold;
      // Slow clock: bit n is also settled at rise n
      rbits1[n] = w1;
      rbits2[n] = w2;
      sclk = 1'b1;
      #100 if (n == 13) hold_post = hold;
    end
    oe_end = oe1 | oe2;
    cs_n = 1'b1;
    #125 oe_rel = oe1 | oe2;
    hold_end = hold;
    #400;
  endtask : frame
endmodule : dsr_host
`default_nettype wire

// File: bench/dsr_top_tb_top.sv
// Self-checking bench for the dual readout block
`timescale 1ns/1ps
`default_nettype none
module dsr_top_tb_top;
  import dsr_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [RES_W-1:0] res_a = '0;
  logic [RES_W-1:0] res_b = '0;
  wire logic cs_n, sclk, d1, oe1, d2, oe2, hold;
  int err_total = 0;
  int checks_done = 0;
  always #12.5 core_clk = ~core_clk;
  dsr_top i_dut (.CORE_CLK(core_clk), .RESETN(resetn), .CHIP_SELECT_N(cs_n),
    .SERIAL_CLK(sclk), .RESULT_A(res_a), .RESULT_B(res_b), .SERIAL_OUT_FIRST(d1),
    .SERIAL_OUT_FIRST_OE(oe1), .SERIAL_OUT_SECOND(d2), .SERIAL_OUT_SECOND_OE(oe2),
    .HOLD_ACTIVE(hold));
  dsr_host u_host (.clk(core_clk), .d1(d1), .oe1(oe1), .d2(d2), .oe2(oe2),
    .hold(hold), .cs_n(cs_n), .sclk(sclk));
  // Expected bit k of a line: two zeros, own result, two zeros, then the same with the other result
  function automatic logic expb(input int k, input logic [11:0] own,
                                input logic [11:0] oth);
    if (k >= 2 && k < 14) return own[13-k];
    if (k >= 18 && k < 30) return oth[29-k];
    return 1'b0;
  endfunction : expb
  task automatic chk(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Watchdog, well past twelve full frames
  initial begin
    #400000;
    err_total++;
    results();
  end
  // Abort, single, sixteen and extended reads with random results, except fff and 000 in the first extended read
  initial begin
    int lens[4];
    int nf;
    lens = '{5, 14, 16, 32};
    void'($urandom(32'h5d2ca099));
    repeat (12) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(oe1 | oe2, 1'b0, "drive before first select");
    chk(hold, 1'b0, "hold before first select");
    for (int i = 0; i < 12; i++) begin
      nf = lens[i % 4];
      @(posedge core_clk);
      #1 res_a = (i == 3) ? 12'hfff : 12'($urandom);
      res_b = (i == 3) ? 12'h000 : 12'($urandom);
      u_host.frame(nf);
      for (int k = 0; k < nf; k++) begin
        chk(u_host.bits1[k], expb(k, res_a, res_b), "first line bit");
        chk(u_host.bits2[k], expb(k, res_b, res_a), "second line bit");
        if (k > 0) begin
          chk(u_host.rbits1[k], expb(k, res_a, res_b), "first line at rise");
          chk(u_host.rbits2[k], expb(k, res_b, res_a), "second line at rise");
        end
      end
      chk(u_host.hold_sel, 1'b1, "hold at select");
      if (nf >= 14) begin
        chk(u_host.hold_pre, 1'b1, "hold after 13 falls");
        chk(u_host.hold_post, 1'b0, "track after next rise");
      end
      chk(u_host.oe_end, nf < 32, "drive at frame end");
      chk(u_host.oe_rel, 1'b0, "release on select rise");
      chk(u_host.hold_end, 1'b0, "track after abort");
    end
    results();
  end
endmodule : dsr_top_tb_top
`default_nettype wire
